// ==== pte_consts.svh ====
// register offsets, field positions, reset values and timing constants for the test extension bank
`ifndef PTE_CONSTS_SVH
`define PTE_CONSTS_SVH
`define PTE_ADDR_W 5
`define PTE_OFS_EXT 5'h1b
`define PTE_OFS_CTL2 5'h1c
`define PTE_EXT_RESET 8'h00
`define PTE_SYNC_RESET 1'b0
`define PTE_RDATA_RESET 16'h0000
`define PTE_ERR_MAX 8'hff
`define PTE_ERR_ONE 8'h01
`define PTE_ERR_ZERO 8'h00
`define PTE_BIT_RSVD 7
`define PTE_BIT_CLKEN 6
`define PTE_BIT_CONT 5
`define PTE_BIT_PATEN 4
`define PTE_BIT_PULL 3
`define PTE_BIT_GAP 2
`define PTE_BIT_SYNC 13
`define PTE_GAP_LONG_US 15
`define PTE_GAP_SHORT_US 10
`define PTE_CLK_MHZ 50
`define PTE_GAP_LONG_CYC (`PTE_GAP_LONG_US * `PTE_CLK_MHZ)
`define PTE_GAP_SHORT_CYC (`PTE_GAP_SHORT_US * `PTE_CLK_MHZ)
`define PTE_GAP_W 10
`endif

// ==== pte_pkg.sv ====
// types for the test extension register bank
package pte_pkg;
  typedef enum logic [1:0] {
    PTE_PAT_DATA_END_OF_PACKET_TYPE_ZERO,
    PTE_PAT_DATA_END_OF_PACKET_TYPE_ONE,
    PTE_PAT_LINK_PULSE,
    PTE_PAT_TONE
  } pte_pattern_t;

  // control fields of the extension register
  typedef struct packed {
    logic reserved_bit;
    logic mii_clock_force;
    logic continuous_selftest;
    logic driver_pattern_enable;
    logic mgmt_pullup_enable;
    logic pattern_gap_select;
    pte_pattern_t driver_pattern_select;
  } pte_ext_ctl_t;

  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pte_req_t;

  // context from the rest of the transceiver
  typedef struct packed {
    logic selftest_start;
    logic selftest_running;
    logic nibble_error;
    logic speed_100;
    logic mac_mii;
    logic mac_rmii_master;
    logic mac_rmii_slave;
  } pte_ctx_t;
endpackage : pte_pkg

// ==== pte_regs.sv ====
// test extension and second control register bank with pattern gap timer
//
// Function
// RULE1: count each errored receive nibble while packet self-test runs
// RULE2: clear error count when packet self-test starts again
// RULE3: error count saturates at ff and never wraps
// RULE4: software writes zero to reserved bit 7 of extension register
// RULE5: clock force bit drives tx and rx clocks in any mac mode
// RULE6: without force, rmii slave mode keeps tx and rx clocks off
// RULE7: continuous bit sends pseudorandom data with no gaps
// RULE8: continuous mode acts only while main control starts the test
// RULE9: software sets jabber disable before continuous test at 10 Mb
// RULE10: pattern enable transmits selected driver pattern, else none
// RULE11: pull-up enable bit connects the internal management pull-up
// RULE12: pull-up enable resets only on hardware reset, not soft reset
// RULE13: software leaves pull-up off when management bus is shared
// RULE14: gap between test sequences 15 us if select set, else 10 us
// RULE15: pattern select 00 end_of_packet_type_zero data, 01 end_of_packet_type_one data, 10 link pulses
// RULE16: pattern select 11 sends constant manchester ones tone
// RULE17: top two bits of second control register read zero
// RULE18: sync bit at 100 Mb with mii or rmii master uses recovered clock
// RULE19: otherwise transmitter runs from local reference clock
// RULE20: writes to the error count field change nothing
`timescale 1ns/10ps
`include "pte_consts.svh"
module pte_regs #(
  parameter int GAP_LONG_CYC = `PTE_GAP_LONG_CYC,
  parameter int GAP_SHORT_CYC = `PTE_GAP_SHORT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire pte_pkg::pte_req_t req,
  input wire pte_pkg::pte_ctx_t ctx,
  output logic [15:0] rdata,
  output logic mii_clocks_on,
  output logic continuous_tx,
  output logic pattern_active,
  output pte_pkg::pte_pattern_t pattern_kind,
  output logic pattern_gap_strobe,
  output logic mgmt_pullup_on,
  output logic tx_clk_recovered
);
  pte_pkg::pte_ext_ctl_t ext_q, ext_d;
  logic [7:0] err_q, err_d;
  logic sync_q, sync_d;
  logic [`PTE_GAP_W-1:0] gap_q, gap_d;
  logic strobe_q, strobe_d;
  logic [15:0] rdata_q, rdata_d;
  logic wr_ext, wr_ctl2;
  logic gap_run;

  // true when a strobe addresses the given register; shared by write and read decode
  function automatic logic addr_hit(
    input logic strobe,
    input logic [4:0] addr,
    input logic [4:0] ofs
  );
    addr_hit = strobe && (addr == ofs);
  endfunction : addr_hit

  // control byte as taken from a write; the count byte above it is dropped [RULE20]
  function automatic pte_pkg::pte_ext_ctl_t ext_from_write(
    input logic [15:0] wdata
  );
    ext_from_write = pte_pkg::pte_ext_ctl_t'(wdata[7:0]);
  endfunction : ext_from_write

  // control byte after a soft reset; the pull-up choice survives it [RULE12]
  function automatic pte_pkg::pte_ext_ctl_t ext_after_soft(
    input pte_pkg::pte_ext_ctl_t ctl
  );
    ext_after_soft = pte_pkg::pte_ext_ctl_t'(`PTE_EXT_RESET);
    ext_after_soft.mgmt_pullup_enable = ctl.mgmt_pullup_enable;
  endfunction : ext_after_soft

  // one step of the error count; sticks at the top value instead of wrapping
  function automatic logic [7:0] err_step(
    input logic [7:0] count
  );
    if (count == `PTE_ERR_MAX)
    begin
      err_step = count; // [RULE3]
    end
    else
    begin
      err_step = count + `PTE_ERR_ONE; // [RULE1]
    end
  endfunction : err_step

  // last count of a gap period for the selected gap length
  function automatic logic [`PTE_GAP_W-1:0] gap_end(
    input logic long_gap
  );
    if (long_gap)
    begin
      gap_end = `PTE_GAP_W'(GAP_LONG_CYC - 1); // 15 us [RULE14]
    end
    else
    begin
      gap_end = `PTE_GAP_W'(GAP_SHORT_CYC - 1); // 10 us [RULE14]
    end
  endfunction : gap_end

  // read image of the extension register: count byte over control byte
  function automatic logic [15:0] ext_word(
    input logic [7:0] count,
    input pte_pkg::pte_ext_ctl_t ctl
  );
    ext_word = {count, ctl};
  endfunction : ext_word

  // read image of the second control register; only the sync bit is stored
  function automatic logic [15:0] ctl2_word(
    input logic sync_bit
  );
    ctl2_word = `PTE_RDATA_RESET;
    ctl2_word[`PTE_BIT_SYNC] = sync_bit; // reserved top bits stay zero [RULE17]
  endfunction : ctl2_word

  // address decode for writes
  always_comb
  begin
    wr_ext = 1'b0;
    wr_ctl2 = 1'b0;
    if (addr_hit(req.wr, req.addr, `PTE_OFS_EXT))
    begin
      wr_ext = 1'b1;
    end
    else if (addr_hit(req.wr, req.addr, `PTE_OFS_CTL2))
    begin
      wr_ctl2 = 1'b1;
    end
  end

  // next value of the extension control byte; soft reset wins over a write
  always_comb
  begin
    ext_d = ext_q;
    if (wr_ext)
    begin
      ext_d = ext_from_write(req.wdata); // [RULE20]
    end
    if (soft_rst)
    begin
      ext_d = ext_after_soft(ext_q); // [RULE12]
    end
  end

  // extension control byte register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ext_q <= pte_pkg::pte_ext_ctl_t'(`PTE_EXT_RESET);
    end
    else
    begin
      ext_q <= ext_d;
    end
  end

  // next value of the synchronous transmit bit; other bits of a write are dropped
  always_comb
  begin
    sync_d = sync_q;
    if (wr_ctl2)
    begin
      sync_d = req.wdata[`PTE_BIT_SYNC];
    end
    if (soft_rst)
    begin
      sync_d = `PTE_SYNC_RESET;
    end
  end

  // synchronous transmit bit register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync_q <= `PTE_SYNC_RESET;
    end
    else
    begin
      sync_q <= sync_d;
    end
  end

  // error counter: restart clears and wins over a same-cycle error
  always_comb
  begin
    err_d = err_q;
    if (ctx.selftest_start)
    begin
      err_d = `PTE_ERR_ZERO; // [RULE2]
    end
    else if (ctx.selftest_running && ctx.nibble_error)
    begin
      err_d = err_step(err_q); // [RULE1] [RULE3]
    end
  end

  // error counter register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      err_q <= `PTE_ERR_ZERO;
    end
    else
    begin
      err_q <= err_d;
    end
  end

  // the gap timer runs only for patterns that are sent in bursts
  assign gap_run = ext_q.driver_pattern_enable
                   && (ext_q.driver_pattern_select != pte_pkg::PTE_PAT_TONE); // [RULE16]

  // gap timer between driver test sequences
  always_comb
  begin
    gap_d = gap_q;
    strobe_d = 1'b0;
    if (!gap_run)
    begin
      gap_d = '0;
    end
    else if (gap_q >= gap_end(ext_q.pattern_gap_select)) // [RULE14]
    begin
      gap_d = '0;
      strobe_d = 1'b1;
    end
    else
    begin
      gap_d = gap_q + `PTE_GAP_W'(1);
    end
  end

  // gap timer and strobe registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      gap_q <= '0;
      strobe_q <= 1'b0;
    end
    else
    begin
      gap_q <= gap_d;
      strobe_q <= strobe_d;
    end
  end

  // read data; unknown addresses read zero and the word holds until the next read
  always_comb
  begin
    rdata_d = rdata_q;
    if (addr_hit(req.rd, req.addr, `PTE_OFS_EXT))
    begin
      rdata_d = ext_word(err_q, ext_q);
    end
    else if (addr_hit(req.rd, req.addr, `PTE_OFS_CTL2))
    begin
      rdata_d = ctl2_word(sync_q); // [RULE17]
    end
    else if (req.rd)
    begin
      rdata_d = `PTE_RDATA_RESET;
    end
  end

  // read data register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata_q <= `PTE_RDATA_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // read data goes out straight from its register
  assign rdata = rdata_q;

  // tx and rx clocks: forced on, otherwise off only in rmii slave mode
  assign mii_clocks_on = ext_q.mii_clock_force || !ctx.mac_rmii_slave; // [RULE5] [RULE6]

  // continuous pseudorandom transmit needs the main self-test running
  assign continuous_tx = ext_q.continuous_selftest && ctx.selftest_running; // [RULE7] [RULE8]

  // driver test pattern controls and the gap strobe
  assign pattern_active = ext_q.driver_pattern_enable; // [RULE10]
  assign pattern_kind = ext_q.driver_pattern_select; // [RULE15] [RULE16]
  assign pattern_gap_strobe = strobe_q;

  // internal management pull-up, kept across soft reset
  assign mgmt_pullup_on = ext_q.mgmt_pullup_enable; // [RULE11]

  // transmit clock source: recovered clock only at 100 Mb with mii or rmii master
  assign tx_clk_recovered = sync_q && ctx.speed_100
                            && (ctx.mac_mii || ctx.mac_rmii_master); // [RULE18] [RULE19]
endmodule : pte_regs

// ==== pte_regs_asserts.sv ====
// port checks for the test extension register bank
`timescale 1ns/10ps
module pte_regs_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire pte_pkg::pte_req_t req,
  input wire pte_pkg::pte_ctx_t ctx,
  input wire logic [15:0] rdata,
  input wire logic mii_clocks_on,
  input wire logic continuous_tx,
  input wire logic pattern_active,
  input wire pte_pkg::pte_pattern_t pattern_kind,
  input wire logic pattern_gap_strobe,
  input wire logic mgmt_pullup_on,
  input wire logic tx_clk_recovered
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // writes that the bank accepts
  sequence s_ext; req.wr && req.addr == 5'h1b && !soft_rst; endsequence
  sequence s_sync; req.wr && req.addr == 5'h1c && req.wdata[13] && !soft_rst; endsequence
  a_clk_force: assert property (s_ext ##0 req.wdata[6] |=> mii_clocks_on)
    else $error("clock force lost");
  a_pat_write: assert property (s_ext |=> pattern_active == $past(req.wdata[4])
    && pattern_kind == $past(req.wdata[1:0])) else $error("pattern not taken");
  a_pull_soft: assert property (soft_rst |=> $stable(mgmt_pullup_on))
    else $error("pull-up changed");
  a_cont_run: assert property (continuous_tx |-> ctx.selftest_running)
    else $error("continuous without test");
  a_rsvd_zero: assert property (req.rd && req.addr == 5'h1c |=> rdata[15:14] == 2'h0)
    else $error("reserved bits set");
  a_sync_on: assert property (s_sync ##1 ctx.speed_100 && ctx.mac_mii |-> tx_clk_recovered)
    else $error("sync clock missing");
  a_sync_off: assert property (!ctx.speed_100 || !(ctx.mac_mii || ctx.mac_rmii_master)
    |-> !tx_clk_recovered) else $error("sync clock wrong");
  a_gap_cause: assert property (pattern_gap_strobe |-> $past(pattern_active)
    && $past(pattern_kind) != pte_pkg::PTE_PAT_TONE) else $error("stray gap");
endmodule : pte_regs_asserts

// ==== pte_regs_tb.sv ====
// self-checking bench for the test extension register bank
`timescale 1ns/10ps
module pte_regs_tb;
  logic mclk = 0, rst = 1, soft_rst = 0;
  pte_pkg::pte_req_t req = '0;
  pte_pkg::pte_ctx_t ctx = '0;
  logic [15:0] rdata;
  logic mii_clocks_on, continuous_tx, pattern_active, pattern_gap_strobe;
  logic mgmt_pullup_on, tx_clk_recovered;
  pte_pkg::pte_pattern_t pattern_kind;
  int errors = 0, compares = 0, cyc = 0, n;
  pte_regs #(.GAP_LONG_CYC(8), .GAP_SHORT_CYC(5)) i_dut (
    .mclk(mclk),
    .rst(rst),
    .soft_rst(soft_rst),
    .req(req),
    .ctx(ctx),
    .rdata(rdata),
    .mii_clocks_on(mii_clocks_on),
    .continuous_tx(continuous_tx),
    .pattern_active(pattern_active),
    .pattern_kind(pattern_kind),
    .pattern_gap_strobe(pattern_gap_strobe),
    .mgmt_pullup_on(mgmt_pullup_on),
    .tx_clk_recovered(tx_clk_recovered)
  );
  // free-running clock and hang guard
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      conclude();
    end
  end
  task conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  task cmp(string s, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : cmp
  task wr(logic [4:0] a, logic [15:0] d);
    @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) req.wr <= 1'b0;
    #1;
  endtask : wr
  task rd(logic [4:0] a, logic [15:0] e);
    @(posedge mclk) req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk) req.rd <= 1'b0;
    #1 cmp("rdata", e, rdata);
  endtask : rd
  // spacing between two gap strobes
  task gap(int e);
    @(posedge mclk iff pattern_gap_strobe);
    n = 0;
    do @(posedge mclk) n++; while (!pattern_gap_strobe && n < 20);
    cmp("gap", e, n);
  endtask : gap
  task burst(int c);
    @(posedge mclk) ctx.nibble_error <= 1'b1;
    repeat (c) @(posedge mclk);
    ctx.nibble_error <= 1'b0;
  endtask : burst
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    ctx.mac_rmii_slave <= 1'b1;
    rd(5'h1b, 16'h0000);
    rd(5'h1c, 16'h0000);
    wr(5'h1e, 16'hffff);
    rd(5'h1e, 16'h0000);
    wr(5'h1b, 16'hff7f); // reserved bit 7 written as zero
    rd(5'h1b, 16'h007f);
    cmp("clk", 1, mii_clocks_on);
    cmp("pull", 1, mgmt_pullup_on);
    cmp("cont", 0, continuous_tx);
    @(posedge mclk) soft_rst <= 1'b1;
    @(posedge mclk) soft_rst <= 1'b0;
    rd(5'h1b, 16'h0008);
    cmp("clk", 0, mii_clocks_on);
    $display("register test done");
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h1b, 16'h0010 | 16'(k));
      cmp("kind", k, pattern_kind);
    end
    cmp("pat", 1, pattern_active);
    cmp("pull", 0, mgmt_pullup_on); // pull-up left off for a shared bus
    wr(5'h1b, 16'h0010);
    gap(5);
    wr(5'h1b, 16'h0014);
    gap(8);
    wr(5'h1b, 16'h0000);
    cmp("pat", 0, pattern_active);
    $display("pattern test done");
    @(posedge mclk) ctx.selftest_running <= 1'b1;
    burst(3);
    rd(5'h1b, 16'h0300);
    burst(300);
    rd(5'h1b, 16'hff00);
    @(posedge mclk) ctx.selftest_start <= 1'b1;
    @(posedge mclk) ctx.selftest_start <= 1'b0;
    rd(5'h1b, 16'h0000);
    @(posedge mclk) ctx.speed_100 <= 1'b1; // 100 Mb run needs no jabber setup
    ctx.mac_mii <= 1'b1;
    wr(5'h1b, 16'h0020);
    cmp("cont", 1, continuous_tx);
    wr(5'h1c, 16'hffff);
    rd(5'h1c, 16'h2000);
    cmp("sync", 1, tx_clk_recovered);
    @(posedge mclk) ctx.speed_100 <= 1'b0;
    #1 cmp("sync", 0, tx_clk_recovered);
    $display("self-test and sync test done");
    conclude();
  end
endmodule : pte_regs_tb
bind pte_regs pte_regs_asserts i_chk (
  .mclk(mclk),
  .rst(rst),
  .soft_rst(soft_rst),
  .req(req),
  .ctx(ctx),
  .rdata(rdata),
  .mii_clocks_on(mii_clocks_on),
  .continuous_tx(continuous_tx),
  .pattern_active(pattern_active),
  .pattern_kind(pattern_kind),
  .pattern_gap_strobe(pattern_gap_strobe),
  .mgmt_pullup_on(mgmt_pullup_on),
  .tx_clk_recovered(tx_clk_recovered)
);
